// ==== design/ctp_timer.sv ====
// Module: cascaded two-channel timer with PWM pulse output and AHB-Lite registers
`timescale 1ns/1ns
module ctp_timer (
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  input  wire logic        COMPARE_OUT_PIN_I,
  output logic             COMPARE_OUT_PIN_O,
  output logic             COMPARE_OUT_PIN_OE,
  input  wire logic        CAPTURE_ALT_PIN_I
);
  import ctp_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic ctp_reg_type decode(input logic [31:0] addr);
    logic [29:0] idx;
    idx = addr[31:2];
    if (addr[1:0] != 2'h0) decode = REG_NONE;
    else if (idx == IDX_START[29:0]) decode = REG_START;
    else if (idx == IDX_LO_CTRL[29:0]) decode = REG_LO_CTRL;
    else if (idx == IDX_PIN_MUX[29:0]) decode = REG_PIN_MUX;
    else if (idx == IDX_HALT[29:0]) decode = REG_HALT;
    else if (idx == IDX_UP_CTRL[29:0]) decode = REG_UP_CTRL;
    else if (idx == IDX_UP_MODE[29:0]) decode = REG_UP_MODE;
    else if (idx == IDX_UP_PIN[29:0]) decode = REG_UP_PIN;
    else if (idx == IDX_UP_CNT[29:0]) decode = REG_UP_CNT;
    else if (idx == IDX_GR_FIRST[29:0]) decode = REG_GR_FIRST;
    else if (idx == IDX_GR_SEC[29:0]) decode = REG_GR_SEC;
    else if (idx == IDX_LO_CNT[29:0]) decode = REG_LO_CNT;
    else decode = REG_NONE;
  endfunction

  // Count tick for a channel from its source and edge fields
  function automatic logic src_tick(input logic [2:0] src, input logic [1:0] edg,
                                    input logic [5:0] pre, input logic casc);
    logic [5:0] mask;
    logic       fall;
    logic       rise;
    mask = 6'h00;
    unique case (src)
      SRC_DIV4:  mask = 6'h03;
      SRC_DIV16: mask = 6'h0F;
      SRC_DIV64: mask = 6'h3F;
      default:   mask = 6'h00;
    endcase
    fall = ((pre & mask) == mask);
    rise = ((pre & mask) == (mask >> 1));
    if (src == SRC_DIV1) src_tick = 1'b1;
    else if (src == SRC_CASC) src_tick = casc;
    else if (src > SRC_DIV64) src_tick = 1'b0;
    else if (edg == EDGE_FALL) src_tick = fall;
    else if (edg == EDGE_RISE) src_tick = rise;
    else src_tick = fall | rise;
  endfunction

  function automatic logic pin_act(input logic cur, input logic [1:0] act);
    unique case (act)
      ACT_LOW:  pin_act = 1'b0;
      ACT_HIGH: pin_act = 1'b1;
      ACT_TGL:  pin_act = ~cur;
      default:  pin_act = cur;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  ctp_reg_type sel_ff;
  logic        wr_pend_ff, rd_pend_ff, accept;
  logic [31:0] hrdata_ff, nxt_rdata;

  logic [7:0]  start_ff, lo_ctrl_ff, pin_mux_ff, up_ctrl_ff, up_mode_ff, up_pin_ff;
  logic [15:0] halt_ff, gr_first_ff, gr_sec_ff, lo_cnt, up_cnt;

  assign accept    = HSEL & HTRANS[1] & HREADY;
  // Reads take one wait state so the answer comes from a flip-flop
  assign HREADYOUT = ~rd_pend_ff;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_ff;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      sel_ff     <= REG_NONE;
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
    end else if (accept) begin
      sel_ff     <= decode(HADDR);
      wr_pend_ff <= HWRITE;
      rd_pend_ff <= ~HWRITE;
    end else begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_rdata = RD_ZERO;
    unique case (sel_ff)
      REG_START:    nxt_rdata = {24'h000000, start_ff};
      REG_LO_CTRL:  nxt_rdata = {24'h000000, lo_ctrl_ff};
      REG_PIN_MUX:  nxt_rdata = {24'h000000, pin_mux_ff};
      REG_HALT:     nxt_rdata = {16'h0000, halt_ff};
      REG_UP_CTRL:  nxt_rdata = {24'h000000, up_ctrl_ff};
      REG_UP_MODE:  nxt_rdata = {24'h000000, up_mode_ff};
      REG_UP_PIN:   nxt_rdata = {24'h000000, up_pin_ff};
      REG_UP_CNT:   nxt_rdata = {16'h0000, up_cnt};
      REG_GR_FIRST: nxt_rdata = {16'h0000, gr_first_ff};
      REG_GR_SEC:   nxt_rdata = {16'h0000, gr_sec_ff};
      REG_LO_CNT:   nxt_rdata = {16'h0000, lo_cnt};
      default:      nxt_rdata = RD_ZERO;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      hrdata_ff <= RD_ZERO;
    end else if (rd_pend_ff) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic wr_up_pin;
  assign wr_up_pin = wr_pend_ff && (sel_ff == REG_UP_PIN);

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      start_ff   <= RST_REG8;
      lo_ctrl_ff <= RST_REG8;
      pin_mux_ff <= RST_REG8;
      halt_ff    <= RST_HALT;
      up_ctrl_ff <= RST_REG8;
      up_mode_ff <= RST_REG8;
      up_pin_ff  <= RST_REG8;
    end else if (wr_pend_ff) begin
      unique case (sel_ff)
        REG_START:   start_ff   <= HWDATA[7:0];
        REG_LO_CTRL: lo_ctrl_ff <= HWDATA[7:0];
        REG_PIN_MUX: pin_mux_ff <= HWDATA[7:0];
        REG_HALT:    halt_ff    <= {15'h0000, HWDATA[HALT_BIT]};
        REG_UP_CTRL: up_ctrl_ff <= HWDATA[7:0];
        REG_UP_MODE: up_mode_ff <= {4'h0, HWDATA[3:0]};
        REG_UP_PIN:  up_pin_ff  <= HWDATA[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  logic [2:0] lo_src, up_clr, up_src;
  logic [1:0] lo_edge, up_edge;
  logic [3:0] first_output_control, second_output_control;
  logic       halted, pwm1, phase_md, mux_alt;

  assign lo_src   = lo_ctrl_ff[SRC_LSB +: 3];
  assign lo_edge  = lo_ctrl_ff[EDGE_LSB +: 2];
  assign up_clr   = up_ctrl_ff[CLR_LSB +: 3];
  assign up_src   = up_ctrl_ff[SRC_LSB +: 3];
  assign up_edge  = up_ctrl_ff[EDGE_LSB +: 2];
  assign first_output_control      = up_pin_ff[IOA_LSB +: 4];
  assign second_output_control      = up_pin_ff[IOB_LSB +: 4];
  assign halted   = halt_ff[HALT_BIT];
  assign pwm1     = (up_mode_ff[3:0] == MD_PWM1);
  assign phase_md = (up_mode_ff[3:2] == MD_PHASE);
  assign mux_alt  = pin_mux_ff[MUX_SEL_BIT];

  // ----------------------------------------------------------------
  // Prescaler and count ticks
  // ----------------------------------------------------------------
  logic [5:0] pre_ff;
  logic       lo_run, up_run, lo_tick, up_tick, lo_ovf;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pre_ff <= PRE_ZERO;
    end else if (halted) begin
      pre_ff <= PRE_ZERO;
    end else begin
      pre_ff <= pre_ff + 6'h01;
    end
  end

  assign lo_run  = start_ff[START_LO_BIT] & ~halted;
  assign up_run  = start_ff[START_UP_BIT] & ~halted;
  assign lo_tick = lo_run & src_tick(lo_src, lo_edge, pre_ff, 1'b0);
  // Phase counting has no phase inputs wired here, so the counter holds
  assign up_tick = up_run & ~phase_md & src_tick(up_src, up_edge, pre_ff, lo_ovf);

  // ----------------------------------------------------------------
  // Compare, capture and clear
  // ----------------------------------------------------------------
  logic pin_s1_ff, pin_s2_ff, alt_s1_ff, alt_s2_ff, cap_prev_ff;
  logic cap_in, cap_first, match_first, match_sec, up_clear, same_vals;

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      pin_s1_ff   <= 1'b0;
      pin_s2_ff   <= 1'b0;
      alt_s1_ff   <= 1'b0;
      alt_s2_ff   <= 1'b0;
      cap_prev_ff <= 1'b0;
    end else begin
      pin_s1_ff   <= COMPARE_OUT_PIN_I;
      pin_s2_ff   <= pin_s1_ff;
      alt_s1_ff   <= CAPTURE_ALT_PIN_I;
      alt_s2_ff   <= alt_s1_ff;
      cap_prev_ff <= cap_in;
    end
  end

  assign cap_in    = mux_alt ? alt_s2_ff : pin_s2_ff;
  assign cap_first = first_output_control[3] & ~halted &
                     ((first_output_control[1:0] == 2'h0) ? (cap_in & ~cap_prev_ff) :
                      (first_output_control[1:0] == 2'h1) ? (~cap_in & cap_prev_ff) : (cap_in ^ cap_prev_ff));

  // Match takes effect on the count tick that leaves the matching value
  assign match_first = up_tick & ~first_output_control[3] & (up_cnt == gr_first_ff);
  assign match_sec   = up_tick & ~second_output_control[3] & (up_cnt == gr_sec_ff);
  assign same_vals   = (gr_first_ff == gr_sec_ff);
  assign up_clear    = ((up_clr == CLR_SEC) & match_sec) |
                       ((up_clr == CLR_FIRST) & (match_first | cap_first));

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      gr_first_ff <= RST_GR;
      gr_sec_ff   <= RST_GR;
    end else begin
      if (wr_pend_ff && sel_ff == REG_GR_FIRST) gr_first_ff <= HWDATA[15:0];
      else if (cap_first) gr_first_ff <= up_cnt;
      if (wr_pend_ff && sel_ff == REG_GR_SEC) gr_sec_ff <= HWDATA[15:0];
    end
  end

  // ----------------------------------------------------------------
  // Counters
  // ----------------------------------------------------------------
  // No compare registers on the lower channel: it only wraps
  ctp_counter #(.W(CNT_W)) u_lower (
    .clk      (REF_CLK),
    .rstn     (RESETN),
    .count_en (lo_tick),
    .clear    (1'b0),
    .load     (wr_pend_ff && sel_ff == REG_LO_CNT),
    .load_val (HWDATA[15:0]),
    .value    (lo_cnt),
    .wrap     (lo_ovf)
  );

  ctp_counter #(.W(CNT_W)) u_upper (
    .clk      (REF_CLK),
    .rstn     (RESETN),
    .count_en (up_tick),
    .clear    (up_clear),
    .load     (wr_pend_ff && sel_ff == REG_UP_CNT),
    .load_val (HWDATA[15:0]),
    .value    (up_cnt),
    .wrap     ()
  );

  // ----------------------------------------------------------------
  // Pulse output
  // ----------------------------------------------------------------
  logic out_ff;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      out_ff <= 1'b0;
    end else if (wr_up_pin) begin
      out_ff <= HWDATA[IOA_LSB + 2];
    end else if (pwm1) begin
      if (same_vals || (match_first && match_sec)) begin
        out_ff <= out_ff;
      end else if (match_sec) begin
        out_ff <= pin_act(out_ff, second_output_control[1:0]);
      end else if (match_first) begin
        out_ff <= pin_act(out_ff, first_output_control[1:0]);
      end
    end else if (match_first) begin
      out_ff <= pin_act(out_ff, first_output_control[1:0]);
    end
  end

  assign COMPARE_OUT_PIN_O  = out_ff;
  // Pin is driven only for compare output; capture on it leaves it free
  assign COMPARE_OUT_PIN_OE = ~first_output_control[3] & (first_output_control != 4'h0);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  logic sw_up, sw_lo;
  assign sw_up = wr_pend_ff && (sel_ff == REG_UP_CNT);
  assign sw_lo = wr_pend_ff && (sel_ff == REG_LO_CNT);

  sequence lo_at_top_s;
    lo_tick && lo_cnt == CNT_MAX && !sw_lo;
  endsequence
  sequence up_step_s;
    lo_ovf ##0 (up_tick && !up_clear && !sw_up);
  endsequence

  upper_clear_a: assert property ((match_sec && up_clr == CLR_SEC && !sw_up) |=> up_cnt == CNT_ZERO)
    else $error("upper counter not cleared on second match");
  cascade_step_a: assert property ((up_src == SRC_CASC && up_run && !phase_md) |-> up_tick == lo_ovf)
    else $error("upper tick not tied to lower overflow");
  upper_count_a: assert property (up_step_s |=> up_cnt == $past(up_cnt) + 16'h0001)
    else $error("upper counter missed a cascade step");
  lower_every_a: assert property ((lo_run && lo_src == SRC_DIV1 && !sw_lo && lo_cnt != CNT_MAX)
                                  |=> lo_cnt == $past(lo_cnt) + 16'h0001)
    else $error("lower counter not advancing each clock");
  lower_wrap_a: assert property (lo_at_top_s |-> lo_ovf ##1 (lo_cnt == CNT_ZERO && !lo_ovf))
    else $error("lower wrap pulse wrong");
  pwm_set_a: assert property ((pwm1 && first_output_control == IO_SET1 && match_first && !match_sec && !same_vals && !wr_up_pin)
                              |=> out_ff)
    else $error("pulse not set on first match");
  pwm_reset_a: assert property ((pwm1 && second_output_control == IO_CLR0 && match_sec && !same_vals && !wr_up_pin)
                                |=> !out_ff)
    else $error("pulse not cleared on second match");
  equal_hold_a: assert property ((pwm1 && same_vals && !wr_up_pin) |=> $stable(out_ff))
    else $error("pulse changed with equal compare values");
  stop_hold_a: assert property ((!start_ff[START_UP_BIT] && !sw_up && !cap_first) |=> $stable(up_cnt))
    else $error("stopped upper counter moved");
  halt_hold_a: assert property ((halted && !sw_lo) [*2] |-> $stable(lo_cnt))
    else $error("halted lower counter moved");
  phase_hold_a: assert property (phase_md |-> !up_tick)
    else $error("phase mode upper counter cascaded");
  lower_noclr_a: assert property ((lo_tick && !sw_lo && lo_cnt != CNT_MAX) |=> lo_cnt != CNT_ZERO)
    else $error("lower counter cleared unexpectedly");

endmodule

// ==== design/ctp_pkg.sv ====
// Package: register map, field layout, codes and reset values of the cascaded timer
package ctp_pkg;

  localparam int CNT_W = 16;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_START    = 32'h000F_FFBC;
  localparam logic [31:0] IDX_LO_CTRL  = 32'h00FF_EA41;
  localparam logic [31:0] IDX_PIN_MUX  = 32'h00FF_FBC9;
  localparam logic [31:0] IDX_HALT     = 32'h00FF_FDC8;
  localparam logic [31:0] IDX_UP_CTRL  = 32'h00FF_FEE0;
  localparam logic [31:0] IDX_UP_MODE  = 32'h00FF_FEE1;
  localparam logic [31:0] IDX_UP_PIN   = 32'h00FF_FEE2;
  localparam logic [31:0] IDX_UP_CNT   = 32'h00FF_FEE6;
  localparam logic [31:0] IDX_GR_FIRST = 32'h00FF_FEE8;
  localparam logic [31:0] IDX_GR_SEC   = 32'h00FF_FEEA;
  localparam logic [31:0] IDX_LO_CNT   = 32'h00FF_EA46;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int START_LO_BIT = 5;
  localparam int START_UP_BIT = 4;
  localparam int MUX_SEL_BIT  = 6;
  localparam int HALT_BIT     = 0;
  localparam int CLR_LSB      = 5;
  localparam int EDGE_LSB     = 3;
  localparam int SRC_LSB      = 0;
  localparam int IOB_LSB      = 4;
  localparam int IOA_LSB      = 0;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CLR_NONE  = 3'h0;
  localparam logic [2:0] CLR_FIRST = 3'h1;
  localparam logic [2:0] CLR_SEC   = 3'h2;
  localparam logic [2:0] SRC_DIV1  = 3'h0;
  localparam logic [2:0] SRC_DIV4  = 3'h1;
  localparam logic [2:0] SRC_DIV16 = 3'h2;
  localparam logic [2:0] SRC_DIV64 = 3'h3;
  localparam logic [2:0] SRC_CASC  = 3'h7;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [3:0] MD_PWM1   = 4'h2;
  localparam logic [1:0] MD_PHASE  = 2'h1;
  localparam logic [1:0] ACT_LOW   = 2'h1;
  localparam logic [1:0] ACT_HIGH  = 2'h2;
  localparam logic [1:0] ACT_TGL   = 2'h3;
  localparam logic [3:0] IO_SET1   = 4'h2;
  localparam logic [3:0] IO_CLR0   = 4'h5;

  // ----------------------------------------------------------------
  // Reset values and counter limits
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_REG8  = 8'h00;
  localparam logic [15:0] RST_HALT  = 16'h0001;
  localparam logic [15:0] RST_GR    = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO  = 16'h0000;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [31:0] RD_ZERO   = 32'h0000_0000;
  localparam logic [5:0]  PRE_ZERO  = 6'h00;

  typedef enum logic [3:0] {
    REG_NONE, REG_START, REG_LO_CTRL, REG_PIN_MUX, REG_HALT, REG_UP_CTRL,
    REG_UP_MODE, REG_UP_PIN, REG_UP_CNT, REG_GR_FIRST, REG_GR_SEC, REG_LO_CNT
  } ctp_reg_type;

endpackage

// ==== design/ctp_counter.sv ====
// Module: one 16-bit channel counter with load, clear and wrap pulse
`timescale 1ns/1ns
module ctp_counter #(
  parameter int W = 16
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic         count_en,
  input  wire logic         clear,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  output logic      [W-1:0] value,
  output logic              wrap
);
  logic [W-1:0] value_ff;

  assign value = value_ff;
  // One-cycle pulse on the step from all ones to zero
  assign wrap  = count_en & (&value_ff) & ~clear & ~load;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value_ff <= '0;
    end else if (load) begin
      value_ff <= load_val;
    end else if (clear) begin
      value_ff <= '0;
    end else if (count_en) begin
      value_ff <= value_ff + {{(W-1){1'b0}}, 1'b1};
    end
  end
endmodule

// ==== tb/ctp_pulse_sink.sv ====
// Partner model: external receiver on the pulse pin, with a pull-down on the line
`timescale 1ns/1ns
module ctp_pulse_sink (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       pin_o,
  input  wire logic       pin_oe,
  output logic            level,
  output logic      [7:0] rise_cnt_ff
);
  logic last_ff;

  // Released line falls to the pull-down level, never keeps the last value
  assign level = pin_oe ? pin_o : 1'b0;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      last_ff     <= 1'b0;
      rise_cnt_ff <= 8'h00;
    end else begin
      last_ff <= level;
      if (level && !last_ff) begin
        rise_cnt_ff <= rise_cnt_ff + 8'h01;
      end
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// Testbench: cascaded timer registers, pulse output and capture routing
`timescale 1ns/1ns
module tb_top;
  import ctp_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  logic        clk, rstn, hsel, hwrite, hready_out, hresp, pin_o, pin_oe, pin_lvl, alt_pin;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] a, b;
  logic [16:0] e;
  logic [7:0]  rise_cnt, base;
  int          error_cnt, num_checks;
  int          cyc = 0;

  ctp_timer u_dut (
    .REF_CLK(clk), .RESETN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready_out), .HRDATA(hrdata), .HREADYOUT(hready_out),
    .HRESP(hresp), .COMPARE_OUT_PIN_I(pin_lvl), .COMPARE_OUT_PIN_O(pin_o),
    .COMPARE_OUT_PIN_OE(pin_oe), .CAPTURE_ALT_PIN_I(alt_pin)
  );
  ctp_pulse_sink u_sink (
    .clk(clk), .rstn(rstn), .pin_o(pin_o), .pin_oe(pin_oe), .level(pin_lvl), .rise_cnt_ff(rise_cnt)
  );

  always #4 clk = ~clk;
  always @(posedge clk) alt_pin <= 1'($urandom);
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      error_cnt++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // Bus tasks and expectation model
  // ----------------------------------------------------------------
  // Entered just after a rising edge; ready and read data are taken at the rising edge
  task automatic xfer(input logic [31:0] idx, input logic wr, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= idx << 2;
    hwrite <= wr;
    do begin @(posedge clk); end while (hready_out !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin @(posedge clk); end while (hready_out !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] idx, input logic [31:0] d);
    logic [31:0] x;
    xfer(idx, 1'b1, d, x);
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdc(input string nm, input logic [31:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    xfer(idx, 1'b0, 32'h0, d);
    chk(nm, exp, d);
    chk("response", 32'h0, 32'(hresp));
  endtask
  // One lower wrap: 16 counts from the preset, with margin
  task automatic tick;
    wr(IDX_LO_CNT, 32'h0000_FFF0);
    repeat (24) @(posedge clk);
  endtask
  function automatic logic [16:0] model(input int k, input logic [15:0] fa, input logic [15:0] fb);
    logic [15:0] u;
    logic        p;
    u = 16'h0000;
    p = 1'b0;
    for (int i = 0; i < k; i++) begin
      if (u == fa && fa != fb) p = 1'b1;
      if (u == fb) begin
        if (fa != fb) p = 1'b0;
        u = 16'h0000;
      end else begin
        u = u + 16'h0001;
      end
    end
    return {p, u};
  endfunction
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0; rstn = 1'b0; hsel = 1'b0; hwrite = 1'b0; htrans = 2'h0; hsize = 3'h2;
    haddr = 32'h0; hwdata = 32'h0; alt_pin = 1'b0; error_cnt = 0; num_checks = 0;
    r = $urandom(5);
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rdc("halt", IDX_HALT, 32'h1);
    rdc("first", IDX_GR_FIRST, 32'hFFFF);
    rdc("lower", IDX_LO_CNT, 32'h0);
    rdc("unmapped", 32'h40, 32'h0);
    for (int i = 0; i < 4; i++) begin
      r = $urandom;
      wr(IDX_GR_SEC, r);
      rdc("second", IDX_GR_SEC, {16'h0, r[15:0]});
      wr(IDX_UP_CNT, r);
      rdc("upper", IDX_UP_CNT, {16'h0, r[15:0]});
    end
    $display("test registers done");
    wr(IDX_LO_CTRL, 32'h0);
    wr(IDX_UP_CTRL, 32'({CLR_SEC, EDGE_FALL, SRC_CASC}));
    wr(IDX_UP_MODE, 32'(MD_PWM1));
    wr(IDX_START, 32'h30);
    tick();
    rdc("halted lower", IDX_LO_CNT, 32'hFFF0);
    wr(IDX_HALT, 32'h0);
    $display("test halt done");
    for (int c = 0; c < 2; c++) begin
      a = (c == 0) ? 16'h1 : 16'h2;
      b = (c == 0) ? 16'h3 : 16'h2;
      wr(IDX_START, 32'h0);
      wr(IDX_GR_FIRST, 32'(a));
      wr(IDX_GR_SEC, 32'(b));
      wr(IDX_UP_CNT, 32'h0);
      wr(IDX_UP_PIN, 32'({IO_CLR0, IO_SET1}));
      wr(IDX_START, 32'h30);
      chk("oe", 32'h1, 32'(pin_oe));
      base = rise_cnt;
      for (int k = 1; k <= 8; k++) begin
        tick();
        e = model(k, a, b);
        rdc("upper", IDX_UP_CNT, 32'(e[15:0]));
        chk("pin", 32'(e[16]), 32'(pin_lvl));
      end
      chk("rises", (c == 0) ? 32'h2 : 32'h0, 32'(rise_cnt - base));
      $display("test pulse case %0d done", c);
    end
    wr(IDX_START, 32'h20);
    tick();
    rdc("upper held", IDX_UP_CNT, 32'(e[15:0]));
    wr(IDX_START, 32'h10);
    tick();
    rdc("lower held", IDX_LO_CNT, 32'hFFF0);
    wr(IDX_UP_MODE, 32'h4);
    wr(IDX_START, 32'h30);
    tick();
    rdc("phase upper", IDX_UP_CNT, 32'(e[15:0]));
    $display("test start and phase done");
    wr(IDX_LO_CTRL, 32'(SRC_DIV4));
    wr(IDX_LO_CNT, 32'h0);
    wr(IDX_START, 32'h20);
    repeat (64) @(posedge clk);
    xfer(IDX_LO_CNT, 1'b0, 32'h0, r);
    chk("quarter rate", 32'h1, 32'(r == 32'h10 || r == 32'h11));
    $display("test prescaler done");
    wr(IDX_START, 32'h0);
    wr(IDX_UP_MODE, 32'h0);
    wr(IDX_UP_PIN, 32'h8);
    wr(IDX_PIN_MUX, 32'h40);
    chk("oe capture", 32'h0, 32'(pin_oe));
    wr(IDX_UP_CNT, 32'h1234);
    repeat (16) @(posedge clk);
    rdc("capture alt", IDX_GR_FIRST, 32'h1234);
    wr(IDX_PIN_MUX, 32'h0);
    wr(IDX_UP_CNT, 32'h55);
    repeat (16) @(posedge clk);
    rdc("capture main", IDX_GR_FIRST, 32'h1234);
    $display("test capture routing done");
    results();
  end
endmodule
